// ===== shared/tcu_pkg.sv
// package for the 8-bit timer/counter compare unit
package tcu_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] TCU_OFF_CTRL_A = 12'h000;
  localparam logic [11:0] TCU_OFF_CTRL_B = 12'h004;
  localparam logic [11:0] TCU_OFF_COUNT = 12'h008;
  localparam logic [11:0] TCU_OFF_CMP_A = 12'h00c;
  localparam logic [11:0] TCU_OFF_CMP_B = 12'h010;
  localparam logic [11:0] TCU_OFF_MASK = 12'h014;
  localparam logic [11:0] TCU_OFF_FLAG = 12'h018;
  localparam logic [11:0] TCU_OFF_OUT = 12'h01c;
  // control_reg_a fields
  localparam int TCU_CA_WM0 = 0;
  localparam int TCU_CA_WM1 = 1;
  localparam int TCU_CA_COMB_LO = 4;
  localparam int TCU_CA_COMA_LO = 6;
  // control_reg_b fields
  localparam int TCU_CB_CS_LO = 0;
  localparam int TCU_CB_WM2 = 3;
  localparam int TCU_CB_FOCB = 6;
  localparam int TCU_CB_FOCA = 7;
  // flag / mask bit positions
  localparam int TCU_FL_OVF = 0;
  localparam int TCU_FL_MA = 1;
  localparam int TCU_FL_MB = 2;
  // reset values and extremes
  localparam logic [7:0] TCU_RST_BYTE = 8'h00;
  localparam logic [7:0] TCU_BOTTOM = 8'h00;
  localparam logic [7:0] TCU_MAX = 8'hff;
  // clock select codes
  localparam logic [2:0] TCU_CS_STOP = 3'h0;
  localparam logic [2:0] TCU_CS_DIRECT = 3'h1;
  localparam logic [2:0] TCU_CS_PRE8 = 3'h2;
  localparam logic [2:0] TCU_CS_PRE64 = 3'h3;
  localparam logic [2:0] TCU_CS_PRE256 = 3'h4;
  localparam logic [2:0] TCU_CS_PRE1024 = 3'h5;
  localparam logic [2:0] TCU_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TCU_CS_EXT_RISE = 3'h7;
  // wave_mode codes
  localparam logic [2:0] TCU_WM_NORMAL = 3'h0;
  localparam logic [2:0] TCU_WM_PC_FF = 3'h1;
  localparam logic [2:0] TCU_WM_CTC = 3'h2;
  localparam logic [2:0] TCU_WM_FAST_FF = 3'h3;
  localparam logic [2:0] TCU_WM_PC_A = 3'h5;
  localparam logic [2:0] TCU_WM_FAST_A = 3'h7;
  // out_action codes
  localparam logic [1:0] TCU_OA_NONE = 2'h0;
  localparam logic [1:0] TCU_OA_TOGGLE = 2'h1;
  localparam logic [1:0] TCU_OA_CLEAR = 2'h2;
  localparam logic [1:0] TCU_OA_SET = 2'h3;
endpackage

// ===== design/tcu_timer.sv
// 8-bit timer/counter with two compare units behind an apb slave
// Overview of operation
// - counter and both compare registers are eight bits wide
// - all flags in one flag register, each masked by a mask register bit
// - tick from prescaler or external pin edges; clock select zero stops counting
// - bottom is 0x00, max is 0xff
// - top is 0xff or compare a, depending on mode
// - each tick clears, increments or decrements the counter per mode
// - counter readable and writable anytime; cpu write beats clear or count
// - three-bit wave mode: two bits in control a, one in control b
// - overflow flag set where the mode dictates and can raise an interrupt
// - equality sets the compare flag on the next tick, irq if enabled
// - flag clears on interrupt acknowledge or on software writing one
// - outputs derived from match, wave mode, out action, max and bottom
// - compare registers double buffered in pwm modes only
// - buffered value loads into working compare only at top or bottom
// - cpu reaches buffer when buffered, working register otherwise
// - force strobe in non-pwm modes acts as match without flag or clear
// - counter write blocks compare matches for the next tick cycle
// - waveform output states are kept across mode changes
// - out action changes act immediately, not buffered
// - reset clears the waveform output state registers to zero
// - in normal mode overflow is set in the tick the counter becomes zero
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tcu_timer
  import tcu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] prescale_tap,
  input wire logic ext_count_pin,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  output logic wave_out_a,
  output logic wave_out_b
);
  logic [7:0] control_reg_a;
  logic [7:0] control_reg_b;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] cmp_buf_a;
  logic [7:0] cmp_buf_b;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_flag_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;
  logic count_dn_reg;
  logic block_reg;
  logic [1:0] match_d_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [2:0] irq_req_reg;
  logic [1:0] wave_reg;

  logic [2:0] clock_select;
  logic [2:0] wave_mode;
  logic timer_tick;
  logic is_pwm;
  logic is_pc;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic wr_acc;
  logic rd_acc;
  logic wr_count;
  logic addr_ok;
  logic [1:0] match_raw;
  logic [1:0] match_ev;
  logic [1:0] out_action [2];
  logic [1:0] force_strobe;
  logic [7:0] count_next;
  logic count_dn_next;

  assign clock_select = control_reg_b[TCU_CB_CS_LO +: 3];
  assign wave_mode = {control_reg_b[TCU_CB_WM2], control_reg_a[TCU_CA_WM1],
                      control_reg_a[TCU_CA_WM0]};
  assign is_pwm = (wave_mode != TCU_WM_NORMAL) && (wave_mode != TCU_WM_CTC);
  assign is_pc = (wave_mode == TCU_WM_PC_FF) || (wave_mode == TCU_WM_PC_A);
  assign out_action[0] = control_reg_a[TCU_CA_COMA_LO +: 2];
  assign out_action[1] = control_reg_a[TCU_CA_COMB_LO +: 2];
  assign force_strobe = {pwdata[TCU_CB_FOCB], pwdata[TCU_CB_FOCA]};

  // apb decode; zero wait states
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign wr_count = wr_acc && (paddr == TCU_OFF_COUNT);
  assign addr_ok = (paddr == TCU_OFF_CTRL_A) || (paddr == TCU_OFF_CTRL_B) ||
                   (paddr == TCU_OFF_COUNT) || (paddr == TCU_OFF_CMP_A) ||
                   (paddr == TCU_OFF_CMP_B) || (paddr == TCU_OFF_MASK) ||
                   (paddr == TCU_OFF_FLAG) || (paddr == TCU_OFF_OUT);

  // top and extreme values
  always_comb begin
    if ((wave_mode == TCU_WM_CTC) || (wave_mode == TCU_WM_PC_A) ||
        (wave_mode == TCU_WM_FAST_A)) begin
      top_val = compare_value_a;
    end else begin
      top_val = TCU_MAX;
    end
  end
  assign at_top = (count_value == top_val);
  assign at_bottom = (count_value == TCU_BOTTOM);

  // external pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_count_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end

  // clock select: one-cycle tick enable
  always_comb begin
    unique case (clock_select)
      TCU_CS_STOP: timer_tick = 1'b0;
      TCU_CS_DIRECT: timer_tick = 1'b1;
      TCU_CS_PRE8: timer_tick = prescale_tap[0];
      TCU_CS_PRE64: timer_tick = prescale_tap[1];
      TCU_CS_PRE256: timer_tick = prescale_tap[2];
      TCU_CS_PRE1024: timer_tick = prescale_tap[3];
      TCU_CS_EXT_FALL: timer_tick = ext_prev_reg && !ext_sync2_reg;
      TCU_CS_EXT_RISE: timer_tick = !ext_prev_reg && ext_sync2_reg;
    endcase
  end

  // counter next value per mode
  always_comb begin
    count_next = count_value;
    count_dn_next = count_dn_reg;
    if (wr_count) begin
      count_next = pwdata[7:0];
    end else if (timer_tick) begin
      if (is_pc) begin
        if (count_dn_reg) begin
          if (at_bottom) begin
            count_dn_next = 1'b0;
            count_next = count_value + 8'h01;
          end else begin
            count_next = count_value - 8'h01;
          end
        end else if (at_top) begin
          count_dn_next = 1'b1;
          count_next = count_value - 8'h01;
        end else begin
          count_next = count_value + 8'h01;
        end
      end else if ((wave_mode != TCU_WM_NORMAL) && at_top) begin
        count_next = TCU_BOTTOM;
      end else begin
        count_next = count_value + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= TCU_RST_BYTE;
      count_dn_reg <= 1'b0;
    end else begin
      count_value <= count_next;
      count_dn_reg <= count_dn_next;
    end
  end

  // block matches for the tick cycle after a counter write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  assign match_raw = {count_value == compare_value_b, count_value == compare_value_a};
  // match is acted on at the tick after equality is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_d_reg <= 2'b00;
    end else if (wr_count) begin
      match_d_reg <= 2'b00;
    end else if (timer_tick) begin
      match_d_reg <= block_reg ? 2'b00 : match_raw;
    end
  end
  assign match_ev = timer_tick ? match_d_reg : 2'b00;

  // control, mask and compare registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_a <= TCU_RST_BYTE;
      control_reg_b <= TCU_RST_BYTE;
      irq_mask_reg <= 3'h0;
    end else if (wr_acc) begin
      if (paddr == TCU_OFF_CTRL_A) begin
        control_reg_a <= pwdata[7:0];
      end
      if (paddr == TCU_OFF_CTRL_B) begin
        control_reg_b <= {2'b00, pwdata[5:0]}; // strobes never stored
      end
      if (paddr == TCU_OFF_MASK) begin
        irq_mask_reg <= pwdata[2:0];
      end
    end
  end

  logic [7:0] cmp_work [2];
  logic [7:0] cmp_bufr [2];
  logic [11:0] cmp_off [2];
  assign cmp_off[0] = TCU_OFF_CMP_A;
  assign cmp_off[1] = TCU_OFF_CMP_B;
  assign compare_value_a = cmp_work[0];
  assign compare_value_b = cmp_work[1];
  assign cmp_buf_a = cmp_bufr[0];
  assign cmp_buf_b = cmp_bufr[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_unit
      logic load_pt;
      logic wave_next;
      assign load_pt = is_pc ? (timer_tick && at_top) : (timer_tick && at_bottom);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_work[gi] <= TCU_RST_BYTE;
          cmp_bufr[gi] <= TCU_RST_BYTE;
        end else begin
          if (wr_acc && (paddr == cmp_off[gi])) begin
            cmp_bufr[gi] <= pwdata[7:0];
          end
          if (!is_pwm && wr_acc && (paddr == cmp_off[gi])) begin
            cmp_work[gi] <= pwdata[7:0];
          end else if (is_pwm && load_pt) begin
            cmp_work[gi] <= cmp_bufr[gi];
          end
        end
      end
      // waveform generator
      always_comb begin
        wave_next = wave_reg[gi];
        if (!is_pwm) begin
          if (match_ev[gi] || (wr_acc && (paddr == TCU_OFF_CTRL_B) && force_strobe[gi])) begin
            unique case (out_action[gi])
              TCU_OA_NONE: wave_next = wave_reg[gi];
              TCU_OA_TOGGLE: wave_next = !wave_reg[gi];
              TCU_OA_CLEAR: wave_next = 1'b0;
              TCU_OA_SET: wave_next = 1'b1;
            endcase
          end
        end else if (out_action[gi][1] && timer_tick) begin
          if (is_pc) begin
            if (match_ev[gi]) begin
              wave_next = out_action[gi][0] ^ count_dn_reg;
            end
          end else if (match_ev[gi]) begin
            wave_next = out_action[gi][0];
          end else if (at_top) begin
            wave_next = !out_action[gi][0]; // set at bottom when clearing on match, cleared at bottom when setting on match
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wave_reg[gi] <= 1'b0;
        end else begin
          wave_reg[gi] <= wave_next;
        end
      end
    end
  endgenerate

  // flags: hardware set wins over clear
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic ovf_ev;
  always_comb begin
    if (is_pc) begin
      ovf_ev = timer_tick && at_bottom && count_dn_reg;
    end else if (wave_mode == TCU_WM_FAST_A) begin
      ovf_ev = timer_tick && at_top;
    end else begin
      ovf_ev = timer_tick && !wr_count && (count_next == TCU_BOTTOM) &&
               (count_value != TCU_BOTTOM);
    end
  end
  assign flag_set = {match_ev[1], match_ev[0], ovf_ev};
  assign flag_clr = irq_ack | ((wr_acc && (paddr == TCU_OFF_FLAG)) ? pwdata[2:0] : 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg <= 3'h0;
      irq_req_reg <= 3'h0;
    end else begin
      irq_flag_reg <= flag_set | (irq_flag_reg & ~flag_clr);
      irq_req_reg <= (flag_set | (irq_flag_reg & ~flag_clr)) & irq_mask_reg;
    end
  end

  // apb read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && !penable;
      pslverr_reg <= psel && !penable && !addr_ok;
      prdata_reg <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          TCU_OFF_CTRL_A: prdata_reg <= {24'h0, control_reg_a};
          TCU_OFF_CTRL_B: prdata_reg <= {24'h0, control_reg_b};
          TCU_OFF_COUNT: prdata_reg <= {24'h0, count_value};
          TCU_OFF_CMP_A: prdata_reg <= {24'h0, is_pwm ? cmp_buf_a : compare_value_a};
          TCU_OFF_CMP_B: prdata_reg <= {24'h0, is_pwm ? cmp_buf_b : compare_value_b};
          TCU_OFF_MASK: prdata_reg <= {29'h0, irq_mask_reg};
          TCU_OFF_FLAG: prdata_reg <= {29'h0, irq_flag_reg};
          TCU_OFF_OUT: prdata_reg <= {30'h0, wave_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_req = irq_req_reg;
  assign wave_out_a = wave_reg[0];
  assign wave_out_b = wave_reg[1];
  logic unused_rd;
  assign unused_rd = rd_acc;
endmodule
`default_nettype wire

// ===== testbench/tcu_timer_properties.sv
// assertion checker on the apb and output ports of the timer compare unit
`timescale 1ns/10ps
`default_nettype none
module tcu_timer_chk
  import tcu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] irq_req,
  input wire logic wave_out_a,
  input wire logic wave_out_b
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic map_ok;
  assign map_ok = (paddr[1:0] == 2'h0) && (paddr <= TCU_OFF_OUT);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  unmapped_err_a: assert property (pready && !map_ok |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (pready && map_ok |-> !pslverr)
    else $error("error on mapped address");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  wave_read_a: assert property (pready && !pwrite && paddr == TCU_OFF_OUT
    |-> prdata[1:0] == {$past(wave_out_b), $past(wave_out_a)})
    else $error("wave state read differs from outputs");
  wave_reset_a: assert property ($rose(presetn) |-> !wave_out_a && !wave_out_b)
    else $error("wave outputs not zero after reset");
  mask_clear_a: assert property (pready && pwrite && paddr == TCU_OFF_MASK
    && pwdata[2:0] == 3'h0 |-> ##2 irq_req == 3'h0)
    else $error("interrupt request with all masks off");
endmodule
bind tcu_timer tcu_timer_chk tcu_timer_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .wave_out_a(wave_out_a),
  .wave_out_b(wave_out_b));
`default_nettype wire

// ===== testbench/tcu_far_side.sv
// far side model: shared prescaler taps and the external count pin
`timescale 1ns/10ps
`default_nettype none
module tcu_far_side
  import tcu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  output logic ext_count_pin,
  output logic [3:0] prescale_tap
);
  logic [9:0] div_reg;
  logic [4:0] half_reg;
  logic [1:0] gap_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 10'h0;
    end else begin
      div_reg <= div_reg + 10'h1;
    end
  end
  // one-cycle taps at /8 /64 /256 /1024
  assign prescale_tap = {&div_reg, &div_reg[7:0], &div_reg[5:0], &div_reg[2:0]};
  // burst of five pin periods, four clocks per half period, idle low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg <= 5'h0;
      gap_reg <= 2'h0;
      ext_count_pin <= 1'b0;
    end else if (go) begin
      half_reg <= 5'h0a;
      gap_reg <= 2'h0;
    end else if (half_reg != 5'h0) begin
      gap_reg <= gap_reg + 2'h1;
      if (gap_reg == 2'h3) begin
        ext_count_pin <= ~ext_count_pin;
        half_reg <= half_reg - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tcu_timer_test.sv
// self-checking bench for the timer compare unit
`timescale 1ns/10ps
`default_nettype none
module tcu_timer_test
  import tcu_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, wa, wb, go, er, w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] taps;
  logic [2:0] ack, req;
  logic [1:0] oa_list [5] = '{TCU_OA_SET, TCU_OA_TOGGLE, TCU_OA_CLEAR, TCU_OA_TOGGLE, TCU_OA_NONE};
  logic [2:0] cs_list [3] = '{TCU_CS_DIRECT, TCU_CS_PRE8, TCU_CS_PRE64};
  int div_list [3] = '{1, 8, 64};
  int n_mismatch, checked;
  tcu_timer tcu_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prescale_tap(taps), .ext_count_pin(pin), .irq_ack(ack),
    .irq_req(req), .wave_out_a(wa), .wave_out_b(wb));
  tcu_far_side tcu_far_side_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .ext_count_pin(pin), .prescale_tap(taps));
  task automatic conclude();
    $display("compared %0d mismatched %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ack = 3'h0;
    go = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 8; k++) rdc("reset value", 12'(4 * k), 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    wr(TCU_OFF_CMP_A, 32'h1ff);
    rdc("cmp width", TCU_OFF_CMP_A, 32'hff);
    wr(TCU_OFF_COUNT, 32'ha5);
    repeat (20) @(posedge pclk);
    rdc("stopped count", TCU_OFF_COUNT, 32'ha5);
    w = 1'b0;
    foreach (oa_list[k]) begin
      wr(TCU_OFF_CTRL_A, {24'h0, oa_list[k], 6'h0});
      wr(TCU_OFF_CTRL_B, 32'h1 << TCU_CB_FOCA);
      w = (oa_list[k] == TCU_OA_SET) ? 1'b1 : (oa_list[k] == TCU_OA_CLEAR) ? 1'b0 :
        (oa_list[k] == TCU_OA_TOGGLE) ? ~w : w;
      rdc("forced state", TCU_OFF_OUT, {31'h0, w});
    end
    wr(TCU_OFF_CTRL_A, {26'h0, TCU_OA_SET, 4'h0});
    wr(TCU_OFF_CTRL_B, 32'h1 << TCU_CB_FOCB);
    rdc("forced b", TCU_OFF_OUT, 32'h3);
    rdc("force no flag", TCU_OFF_FLAG, 32'h0);
    rdc("force no clear", TCU_OFF_COUNT, 32'ha5);
    wr(TCU_OFF_CTRL_A, {24'h0, TCU_OA_CLEAR, 6'h3});
    wr(TCU_OFF_CTRL_B, 32'h1 << TCU_CB_FOCA);
    rdc("pwm ignores force", TCU_OFF_OUT, 32'h3);
    wr(TCU_OFF_CTRL_A, 32'h0);
    rdc("state kept", TCU_OFF_OUT, 32'h3);
    chk("wave pins", {30'h0, wb, wa}, 32'h3);
    wr(TCU_OFF_CMP_A, 32'h55);
    wr(TCU_OFF_COUNT, 32'h55);
    wr(TCU_OFF_CTRL_B, {29'h0, TCU_CS_DIRECT});
    repeat (20) @(posedge pclk);
    rdc("blocked match", TCU_OFF_FLAG, 32'h0);
    wr(TCU_OFF_MASK, 32'h7);
    repeat (190) @(posedge pclk);
    rdc("overflow and b", TCU_OFF_FLAG, 32'h5);
    chk("irq req", {29'h0, req}, 32'h5);
    ack <= 3'h1;
    @(posedge pclk);
    ack <= 3'h0;
    rdc("ack clears", TCU_OFF_FLAG, 32'h4);
    wr(TCU_OFF_FLAG, 32'h4);
    rdc("w1c clears", TCU_OFF_FLAG, 32'h0);
    repeat (30) @(posedge pclk);
    rdc("match a", TCU_OFF_FLAG, 32'h2);
    chk("irq a", {29'h0, req}, 32'h2);
    wr(TCU_OFF_MASK, 32'h0);
    wr(TCU_OFF_CTRL_B, 32'h0);
    wr(TCU_OFF_CTRL_A, 32'h1 << TCU_CA_WM1);
    wr(TCU_OFF_CMP_A, 32'h5);
    wr(TCU_OFF_COUNT, 32'h0);
    wr(TCU_OFF_CTRL_B, {29'h0, TCU_CS_DIRECT});
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, TCU_OFF_COUNT, 32'h0);
      chk("ctc top", {31'h0, rd <= 32'h5}, 32'h1);
    end
    wr(TCU_OFF_CTRL_B, 32'h0);
    wr(TCU_OFF_CMP_B, 32'h8);
    wr(TCU_OFF_CTRL_A, 32'h3);
    wr(TCU_OFF_COUNT, 32'h10);
    wr(TCU_OFF_FLAG, 32'h7);
    wr(TCU_OFF_CMP_B, 32'h14);
    rdc("buffer read", TCU_OFF_CMP_B, 32'h14);
    wr(TCU_OFF_CTRL_B, {29'h0, TCU_CS_DIRECT});
    repeat (10) @(posedge pclk);
    rdc("buffered cmp", TCU_OFF_FLAG, 32'h0);
    repeat (280) @(posedge pclk);
    xfer(1'b0, TCU_OFF_FLAG, 32'h0);
    chk("loaded cmp", {31'h0, rd[TCU_FL_MB]}, 32'h1);
    wr(TCU_OFF_CTRL_A, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(TCU_OFF_CTRL_B, 32'h0);
      wr(TCU_OFF_COUNT, 32'h0);
      wr(TCU_OFF_CTRL_B, {29'h0, (k == 0) ? TCU_CS_EXT_RISE : TCU_CS_EXT_FALL});
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (60) @(posedge pclk);
      rdc("pin edges", TCU_OFF_COUNT, 32'h5);
    end
    foreach (cs_list[k]) begin
      wr(TCU_OFF_CTRL_B, 32'h0);
      wr(TCU_OFF_COUNT, 32'h0);
      wr(TCU_OFF_CTRL_B, {29'h0, cs_list[k]});
      repeat (128) @(posedge pclk);
      wr(TCU_OFF_CTRL_B, 32'h0);
      xfer(1'b0, TCU_OFF_COUNT, 32'h0);
      chk("tick rate", {31'h0, rd >= 128 / div_list[k] && rd <= 128 / div_list[k] + 4}, 32'h1);
    end
    conclude();
  end
endmodule
`default_nettype wire
